// ===== logic/gpio_params.svh
// Register offsets, field positions, mode codes and reset values of the GPIO block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// Register offsets
`define ADDR_GPIO0_MODE      8'h0D
`define ADDR_GPIO1_2_MODE    8'h0E
`define ADDR_GPIO3_MODE      8'h0F
`define ADDR_REG_GPIO5_6     8'h10
`define ADDR_REG_GPIO7_8     8'h11
`define ADDR_IN_LEVELS_LOW   8'h1C
`define ADDR_IN_LEVELS_HIGH  8'h1D

// Mode codes of one 4-bit field
`define CODE_OUT_LOW         4'h1
`define CODE_INPUT_FWD       4'h3
`define CODE_BACK_OUT        4'h5
`define CODE_OUT_HIGH        4'h9

// Reset value of every mode register: all pins idle
`define MODE_RESET           8'h00

// Field positions
`define FIELD_LO             3:0
`define FIELD_HI             7:4

`endif

// ===== logic/gpio_pkg.sv
// Types shared by the GPIO block
package gpio_pkg;

    // One register access from the local or the remote side
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // Pin control decoded from one mode field
    typedef struct packed {
        logic drive;
        logic level;
        logic sample;
        logic back;
    } pin_ctl_type;

    // Whole state of the GPIO block
    typedef struct packed {
        logic [7:0] mode0;
        logic [7:0] mode12;
        logic [7:0] mode3;
        logic [7:0] mode56;
        logic [7:0] mode78;
        logic [3:0] bc_gpio;
        logic [3:0] gpio_out;
        logic [3:0] gpio_oe;
        logic [3:0] reg_out;
        logic [3:0] reg_oe;
        logic [3:0] fc_gpio;
        logic [3:0] audio;
        logic [1:0] aux;
        logic       irq_mirror;
        logic [7:0] local_rdata;
        logic [7:0] remote_rdata;
    } gpio_state_type;

endpackage : gpio_pkg

// ===== logic/sync_2ff.sv
// Two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
module sync_2ff #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // A zero-width vector cannot be synchronised
    if (WIDTH < 1) begin : g_check
        $error("sync_2ff needs a width of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    // Stage one feeds stage two only
    always_comb begin
        state_next.stage1 = async_i;
        state_next.stage2 = state_reg.stage1;
    end

    // Synchronous reset to all zero
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.stage2;
endmodule : sync_2ff

// ===== logic/gpio_link.sv
// Link and register GPIOs with remote interrupt mirror
`timescale 1ns/1ns
`include "gpio_params.svh"
module gpio_link #(
    parameter int N_LINK_GPIO = 4,
    parameter int N_REG_GPIO  = 4
) (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_n_i,
    // Register access, local and over the control channel
    input  wire gpio_pkg::reg_req_type local_req_i,
    input  wire gpio_pkg::reg_req_type remote_req_i,
    output logic [7:0]                local_rdata_o,
    output logic [7:0]                remote_rdata_o,
    // Serial link state and back channel
    input  wire logic                 link_up_i,
    input  wire logic                 bc_frame_valid_i,
    input  wire logic                 bc_crc_ok_i,
    input  wire logic [3:0]           bc_gpio_i,
    input  wire logic                 far_side_irq_input_i,
    // Forward channel payload GPIO bits
    output logic [3:0]                fc_gpio_o,
    // Remote interrupt pin
    output logic                      remote_irq_mirror_out_o,
    // Link GPIO pins
    input  wire logic [3:0]           gpio_in_i,
    output logic [3:0]                gpio_out_o,
    output logic [3:0]                gpio_oe_o,
    // Register GPIO pins shared with audio serial inputs
    input  wire logic [3:0]           reg_gpio_in_i,
    output logic [3:0]                reg_gpio_out_o,
    output logic [3:0]                reg_gpio_oe_o,
    output logic [3:0]                audio_data_o,
    // Auxiliary audio on link pins 1 and 0
    input  wire logic                 aux_audio_en_i,
    output logic [1:0]                aux_audio_o
);
    // Logic is written for exactly four pins of each kind
    if (N_LINK_GPIO != 4 || N_REG_GPIO != 4) begin : g_check
        $error("gpio_link supports four link and four register GPIOs only");
    end

    gpio_pkg::gpio_state_type state_reg;
    gpio_pkg::gpio_state_type state_next;
    logic [3:0] gpio_sync;
    logic [3:0] reg_sync;

    // Pin levels come from outside the clock domain
    sync_2ff #(.WIDTH(4)) u_sync_gpio (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .async_i   (gpio_in_i),
        .sync_o    (gpio_sync)
    );

    sync_2ff #(.WIDTH(4)) u_sync_reg (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .async_i   (reg_gpio_in_i),
        .sync_o    (reg_sync)
    );

    // Decode one mode field; back channel only exists on link pins
    function automatic gpio_pkg::pin_ctl_type decode(input logic [3:0] code,
                                                     input logic       link_pin);
        gpio_pkg::pin_ctl_type c;
        c = '0;
        case (code)
            `CODE_OUT_LOW:   c.drive = 1'b1;
            `CODE_OUT_HIGH:  begin
                c.drive = 1'b1;
                c.level = 1'b1;
            end
            `CODE_INPUT_FWD: c.sample = 1'b1;
            `CODE_BACK_OUT:  begin
                c.drive = link_pin;
                c.back  = link_pin;
            end
            default:         c = '0;
        endcase
        return c;
    endfunction : decode

    // Mode fields gathered per pin
    logic [3:0][3:0] link_code;
    logic [3:0][3:0] reg_code;
    always_comb begin
        link_code[0] = state_reg.mode0[`FIELD_LO];
        link_code[1] = state_reg.mode12[`FIELD_LO];
        link_code[2] = state_reg.mode12[`FIELD_HI];
        link_code[3] = state_reg.mode3[`FIELD_LO];
        reg_code[0]  = state_reg.mode56[`FIELD_LO];
        reg_code[1]  = state_reg.mode56[`FIELD_HI];
        reg_code[2]  = state_reg.mode78[`FIELD_LO];
        reg_code[3]  = state_reg.mode78[`FIELD_HI];
    end

    // Input levels masked by input mode
    logic [3:0] link_in_lvl;
    logic [3:0] reg_in_lvl;
    always_comb begin
        gpio_pkg::pin_ctl_type lc;
        gpio_pkg::pin_ctl_type rc;
        lc = '0;
        rc = '0;
        for (int i = 0; i < 4; i++) begin
            lc             = decode(link_code[i], 1'b1);
            rc             = decode(reg_code[i], 1'b0);
            link_in_lvl[i] = gpio_sync[i] & lc.sample;
            reg_in_lvl[i]  = reg_sync[i] & rc.sample;
        end
    end

    // Register read mux, reserved bits read zero
    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        case (addr)
            `ADDR_GPIO0_MODE:     return state_reg.mode0;
            `ADDR_GPIO1_2_MODE:   return state_reg.mode12;
            `ADDR_GPIO3_MODE:     return state_reg.mode3;
            `ADDR_REG_GPIO5_6:    return state_reg.mode56;
            `ADDR_REG_GPIO7_8:    return state_reg.mode78;
            `ADDR_IN_LEVELS_LOW:  return {reg_in_lvl[2:0], 1'b0, link_in_lvl};
            `ADDR_IN_LEVELS_HIGH: return {7'h00, reg_in_lvl[3]};
            default:              return 8'h00;
        endcase
    endfunction : read_reg

    // Next state of the whole block
    always_comb begin
        gpio_pkg::pin_ctl_type c;
        gpio_pkg::reg_req_type req;
        c = '0;
        req = '0;
        state_next = state_reg;
        // Remote first so a same-cycle local write wins
        for (int p = 0; p < 2; p++) begin
            req = (p == 0) ? remote_req_i : local_req_i;
            if (req.wr) begin
                case (req.addr)
                    `ADDR_GPIO0_MODE:   state_next.mode0  = req.wdata;
                    `ADDR_GPIO1_2_MODE: state_next.mode12 = req.wdata;
                    `ADDR_GPIO3_MODE:   state_next.mode3  = req.wdata;
                    `ADDR_REG_GPIO5_6:  state_next.mode56 = req.wdata;
                    `ADDR_REG_GPIO7_8:  state_next.mode78 = req.wdata;
                    default:            ;
                endcase
            end
        end
        // Read data registered; holds between reads
        if (local_req_i.rd) begin
            state_next.local_rdata = read_reg(local_req_i.addr);
        end
        if (remote_req_i.rd) begin
            state_next.remote_rdata = read_reg(remote_req_i.addr);
        end
        // Only checked frames update the back-channel bits
        if (bc_frame_valid_i && bc_crc_ok_i) begin
            state_next.bc_gpio = bc_gpio_i;
        end
        // Link pins: local output, back-channel output or forward input
        for (int i = 0; i < 4; i++) begin
            c = decode(link_code[i], 1'b1);
            state_next.gpio_oe[i]  = c.drive;
            state_next.gpio_out[i] = c.back ? state_reg.bc_gpio[i] : c.level;
            state_next.fc_gpio[i]  = c.sample & gpio_sync[i];
        end
        // Aux audio owns pins 1 and 0 while enabled
        if (aux_audio_en_i) begin
            state_next.gpio_oe[1:0]  = 2'b00;
            state_next.gpio_out[1:0] = 2'b00;
            state_next.fc_gpio[1:0]  = 2'b00;
            state_next.aux           = gpio_sync[1:0];
        end else begin
            state_next.aux = 2'b00;
        end
        // Register pins stay local, never forwarded
        for (int i = 0; i < 4; i++) begin
            c = decode(reg_code[i], 1'b0);
            state_next.reg_oe[i]  = c.drive;
            state_next.reg_out[i] = c.level;
            // Any valid GPIO mode cuts the audio input
            state_next.audio[i] = (c.drive | c.sample) ? 1'b0 : reg_sync[i];
        end
        // Mirror is a plain level, high while unlinked
        state_next.irq_mirror = link_up_i ? far_side_irq_input_i : 1'b1;
    end

    // Reset stands for power-down: idle pins, released interrupt
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_reg            <= '0;
            state_reg.mode0      <= `MODE_RESET;
            state_reg.mode12     <= `MODE_RESET;
            state_reg.mode3      <= `MODE_RESET;
            state_reg.mode56     <= `MODE_RESET;
            state_reg.mode78     <= `MODE_RESET;
            state_reg.irq_mirror <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from state flops
    assign local_rdata_o           = state_reg.local_rdata;
    assign remote_rdata_o          = state_reg.remote_rdata;
    assign fc_gpio_o               = state_reg.fc_gpio;
    assign remote_irq_mirror_out_o = state_reg.irq_mirror;
    assign gpio_out_o              = state_reg.gpio_out;
    assign gpio_oe_o               = state_reg.gpio_oe;
    assign reg_gpio_out_o          = state_reg.reg_out;
    assign reg_gpio_oe_o           = state_reg.reg_oe;
    assign audio_data_o            = state_reg.audio;
    assign aux_audio_o             = state_reg.aux;

    // Checks on the block behaviour
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    logic no_wr;
    assign no_wr = !local_req_i.wr && !remote_req_i.wr;

    property p_irq_low;
        (link_up_i && !far_side_irq_input_i) |=> !remote_irq_mirror_out_o;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("mirror not low");

    property p_irq_unlinked;
        !link_up_i |=> remote_irq_mirror_out_o;
    endproperty
    a_irq_unlinked: assert property (p_irq_unlinked) else $error("mirror low unlinked");

    property p_fwd;
        (link_code[0] == `CODE_INPUT_FWD && !aux_audio_en_i)
        |=> fc_gpio_o[0] == $past(gpio_sync[0]);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward bit wrong");

    property p_field12;
        (local_req_i.wr && local_req_i.addr == `ADDR_GPIO1_2_MODE
         && local_req_i.wdata[7:4] == `CODE_OUT_HIGH && !remote_req_i.wr) ##1 no_wr
        |=> (gpio_oe_o[2] && gpio_out_o[2]);
    endproperty
    a_field12: assert property (p_field12) else $error("pin 2 field misplaced");

    property p_drive_high;
        (link_code[3] == `CODE_OUT_HIGH) |=> (gpio_oe_o[3] && gpio_out_o[3]);
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("pin 3 not high");

    property p_reg8_low;
        (reg_code[3] == `CODE_OUT_LOW) |=> (reg_gpio_oe_o[3] && !reg_gpio_out_o[3]);
    endproperty
    a_reg8_low: assert property (p_reg8_low) else $error("pin 8 not low");

    property p_read8;
        (remote_req_i.rd && remote_req_i.addr == `ADDR_IN_LEVELS_HIGH
         && reg_code[3] == `CODE_INPUT_FWD)
        |=> remote_rdata_o == {7'h00, $past(reg_sync[3])};
    endproperty
    a_read8: assert property (p_read8) else $error("pin 8 status wrong");

    property p_audio_cut;
        (reg_code[0] == `CODE_OUT_HIGH) |=> !audio_data_o[0];
    endproperty
    a_audio_cut: assert property (p_audio_cut) else $error("audio not cut");

    property p_remote_rw;
        (remote_req_i.wr && !local_req_i.wr && remote_req_i.addr == `ADDR_GPIO0_MODE)
        ##1 no_wr
        ##1 (local_req_i.rd && local_req_i.addr == `ADDR_GPIO0_MODE && no_wr)
        |=> local_rdata_o == $past(remote_req_i.wdata, 3);
    endproperty
    a_remote_rw: assert property (p_remote_rw) else $error("remote access lost");

    property p_aux;
        aux_audio_en_i |=> gpio_oe_o[1:0] == 2'b00;
    endproperty
    a_aux: assert property (p_aux) else $error("aux pins driven");

    property p_bc_hold;
        !(bc_frame_valid_i && bc_crc_ok_i) |=> $stable(state_reg.bc_gpio);
    endproperty
    a_bc_hold: assert property (p_bc_hold) else $error("back bits changed");

    c_back_out: cover property (link_code[2] == `CODE_BACK_OUT ##2 gpio_out_o[2]);
    c_irq_fall: cover property (link_up_i ##1 !remote_irq_mirror_out_o);
    c_aux_on:   cover property (aux_audio_en_i ##1 aux_audio_o != 2'b00);
endmodule : gpio_link

// ===== verification/deser_model.sv
// Far-side model: back-channel frame source and forward GPIO sink
`timescale 1ns/1ns
module deser_model (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    // Bench controls
    input  wire logic       send_i,
    input  wire logic       crc_bad_i,
    input  wire logic [3:0] bits_i,
    input  wire logic       irq_level_i,
    // Back channel toward the serializer
    output logic            bc_frame_valid_o,
    output logic            bc_crc_ok_o,
    output logic [3:0]      bc_gpio_o,
    output logic            far_side_irq_input_o,
    // Forward payload in, far pins copy it as outputs one cycle later
    input  wire logic [3:0] fc_gpio_i,
    output logic [3:0]      far_pins_o
);
    // Launched just after the edge; between frames the lines keep changing,
    // so a design that samples outside a frame picks up garbage
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            bc_frame_valid_o     <= 1'b0;
            bc_crc_ok_o          <= 1'b0;
            bc_gpio_o            <= 4'h0;
            far_side_irq_input_o <= 1'b1;
            far_pins_o           <= 4'h0;
        end else begin
            bc_frame_valid_o     <= send_i;
            bc_crc_ok_o          <= send_i ? !crc_bad_i : !bc_crc_ok_o;
            bc_gpio_o            <= send_i ? bits_i : ~bc_gpio_o;
            far_side_irq_input_o <= irq_level_i;
            far_pins_o           <= fc_gpio_i;
        end
    end
endmodule : deser_model

// ===== verification/testbench.sv
// Self-checking bench of the GPIO block against the far-side model
`timescale 1ns/1ns
`include "gpio_params.svh"
module testbench;
    // Stimulus
    logic                  clk_sys;
    logic                  reset_n;
    gpio_pkg::reg_req_type local_req;
    gpio_pkg::reg_req_type remote_req;
    logic                  link_up;
    logic                  aux_en;
    logic [3:0]            gpio_in;
    logic [3:0]            reg_gpio_in;
    logic                  send;
    logic                  crc_bad;
    logic [3:0]            bits;
    logic                  irq_level;
    // Observed
    logic [7:0]            local_rdata;
    logic [7:0]            remote_rdata;
    logic                  bc_valid, bc_ok, far_irq, remote_irq;
    logic [3:0]            bc_gpio, fc_gpio, far_pins, gpio_out, gpio_oe;
    logic [3:0]            reg_gpio_out, reg_gpio_oe, audio_data;
    logic [1:0]            aux_audio;
    int                    err_total;
    int                    checks_done;
    // Every readable address, mode registers first
    logic [7:0] reg_addr [7] = '{`ADDR_GPIO0_MODE, `ADDR_GPIO1_2_MODE, `ADDR_GPIO3_MODE,
        `ADDR_REG_GPIO5_6, `ADDR_REG_GPIO7_8, `ADDR_IN_LEVELS_LOW, `ADDR_IN_LEVELS_HIGH};

    gpio_link i_gpio_link (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .local_req_i(local_req),
        .remote_req_i(remote_req), .local_rdata_o(local_rdata), .remote_rdata_o(remote_rdata),
        .link_up_i(link_up), .bc_frame_valid_i(bc_valid), .bc_crc_ok_i(bc_ok),
        .bc_gpio_i(bc_gpio), .far_side_irq_input_i(far_irq), .fc_gpio_o(fc_gpio),
        .remote_irq_mirror_out_o(remote_irq), .gpio_in_i(gpio_in), .gpio_out_o(gpio_out),
        .gpio_oe_o(gpio_oe), .reg_gpio_in_i(reg_gpio_in), .reg_gpio_out_o(reg_gpio_out),
        .reg_gpio_oe_o(reg_gpio_oe), .audio_data_o(audio_data), .aux_audio_en_i(aux_en),
        .aux_audio_o(aux_audio));

    deser_model i_deser_model (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .send_i(send),
        .crc_bad_i(crc_bad), .bits_i(bits), .irq_level_i(irq_level), .bc_frame_valid_o(bc_valid),
        .bc_crc_ok_o(bc_ok), .bc_gpio_o(bc_gpio), .far_side_irq_input_o(far_irq),
        .fc_gpio_i(fc_gpio), .far_pins_o(far_pins));

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Mode register and nibble of pin p (0..3 link, 4..7 register pins 5..8)
    function automatic logic [7:0] f_addr(input int p);
        return (p < 3) ? reg_addr[(p + 1) / 2] : reg_addr[(p + 2) / 2];
    endfunction : f_addr

    function automatic logic f_hi(input int p);
        return (p == 2) || (p == 5) || (p == 7);
    endfunction : f_hi

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic rem, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        if (rem) remote_req <= '{1'b0, 1'b1, a, d};
        else local_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk_sys);
        remote_req <= '0;
        local_req  <= '0;
    endtask : wr

    task automatic rd(input logic rem, input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        if (rem) remote_req <= '{1'b1, 1'b0, a, 8'h00};
        else local_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk_sys);
        remote_req <= '0;
        local_req  <= '0;
        @(negedge clk_sys);
        d = rem ? remote_rdata : local_rdata;
    endtask : rd

    // Let n edges pass, then look where outputs are settled
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : idle

    task automatic set_all(input logic [3:0] code);
        for (int i = 0; i < 5; i++) wr(1'b0, reg_addr[i], {code, code});
    endtask : set_all

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard
    initial begin
        repeat (50000) @(posedge clk_sys);
        err_total++;
        $display("[FAIL] run_time expected end seen timeout");
        tally_and_finish();
    end

    // Main sequence
    initial begin
        logic [7:0] d, e;
        logic [3:0] b, stored;
        logic       bad;
        void'($urandom(32'h3f900c7d));
        reset_n = 1'b0;
        local_req = '0;
        remote_req = '0;
        {link_up, aux_en, send, crc_bad, irq_level} = 5'b00001;
        {gpio_in, reg_gpio_in, bits} = 12'h000;
        err_total = 0;
        checks_done = 0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        idle(1);
        chk("irq_unlinked", 8'h01, {7'h00, remote_irq});
        chk("oe_reset", 8'h00, {reg_gpio_oe, gpio_oe});
        for (int i = 0; i < 7; i++) begin
            rd(i[0], reg_addr[i], d);
            chk("reg_reset", 8'h00, d);
        end
        // Write on one port, read back on the other; RO and unmapped ignore writes
        for (int i = 0; i < 10; i++) begin
            e = 8'($urandom);
            wr(i[0], reg_addr[i / 2], e);
            rd(!i[0], reg_addr[i / 2], d);
            chk("mode_rw", e, d);
        end
        wr(1'b0, `ADDR_IN_LEVELS_LOW, 8'hFF);
        rd(1'b1, `ADDR_IN_LEVELS_LOW, d);
        chk("ro_write", 8'h00, d);
        wr(1'b1, 8'h20, 8'hA5);
        rd(1'b0, 8'h20, d);
        chk("unmapped", 8'h00, d);
        // One pin high among all-low outputs locates each field
        @(posedge clk_sys);
        reg_gpio_in <= 4'($urandom);
        for (int p = 0; p < 8; p++) begin
            set_all(`CODE_OUT_LOW);
            e = f_hi(p) ? {`CODE_OUT_HIGH, `CODE_OUT_LOW} : {`CODE_OUT_LOW, `CODE_OUT_HIGH};
            wr(p[0], f_addr(p), e);
            idle(3);
            chk("pin_level", 8'h01 << p, {reg_gpio_out, gpio_out});
            chk("pin_enable", 8'hFF, {reg_gpio_oe, gpio_oe});
            chk("audio_cut", 8'h00, {4'h0, audio_data});
        end
        // Inputs: status bits, forward payload, far pins, audio override, aux sharing
        set_all(`CODE_INPUT_FWD);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            gpio_in <= 4'($urandom);
            reg_gpio_in <= 4'($urandom);
            aux_en <= (i == 4);
            idle(6);
            rd(1'b0, `ADDR_IN_LEVELS_LOW, d);
            chk("status_low", {reg_gpio_in[2:0], 1'b0, gpio_in}, d);
            rd(1'b1, `ADDR_IN_LEVELS_HIGH, d);
            chk("status_high", {7'h00, reg_gpio_in[3]}, d);
            chk("oe_input", 8'h00, {reg_gpio_oe, gpio_oe});
            chk("audio_cut", 8'h00, {4'h0, audio_data});
            e = aux_en ? {4'h0, gpio_in[3:2], 2'b00} : {4'h0, gpio_in};
            chk("forward_bits", e, {4'h0, fc_gpio});
            chk("far_pins", e, {4'h0, far_pins});
            chk("aux_audio", aux_en ? {6'h00, gpio_in[1:0]} : 8'h00, {6'h00, aux_audio});
        end
        @(posedge clk_sys);
        aux_en <= 1'b0;
        set_all(4'h0);
        idle(4);
        chk("audio_pass", {4'h0, reg_gpio_in}, {4'h0, audio_data});
        chk("forward_idle", 8'h00, {4'h0, fc_gpio});
        // Back channel: checked frames update, failed ones leave the pins alone
        set_all(`CODE_BACK_OUT);
        link_up <= 1'b1;
        stored = 4'h0;
        for (int i = 0; i < 9; i++) begin
            b = 4'($urandom);
            bad = (i % 3 == 2);
            @(posedge clk_sys);
            send <= 1'b1;
            bits <= b;
            crc_bad <= bad;
            @(posedge clk_sys);
            send <= 1'b0;
            if (!bad) stored = b;
            idle(3);
            chk("back_out", {4'h0, stored}, {4'h0, gpio_out});
            chk("back_oe", 8'h0F, {reg_gpio_oe, gpio_oe});
        end
        // Interrupt mirror follows the far level, forced high while unlinked
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_sys);
            link_up <= (i < 2) ? i[0] : 1'($urandom);
            irq_level <= (i < 2) ? 1'b0 : 1'($urandom);
            idle(3);
            e = {7'h00, link_up ? irq_level : 1'b1};
            chk("irq_mirror", e, {7'h00, remote_irq});
        end
        tally_and_finish();
    end
endmodule : testbench
